// ===== tqs_params.svh
`ifndef TQS_PARAMS_SVH
`define TQS_PARAMS_SVH

// ======================================================================
// Register byte offsets
`define TQS_CTRL 8'h00
`define TQS_STATUS 8'h04
`define TQS_INT_STAT 8'h08
`define TQS_INT_MASK 8'h0C
`define TQS_QSEL 8'h10
`define TQS_LEVEL_BASE 8'h20
`define TQS_TERM_BASE 8'h40
`define TQS_TERM_END 8'h5C

// ======================================================================
// Control field positions
`define TQS_CTRL_BEGIN 0
`define TQS_CTRL_HALT 1
`define TQS_CTRL_CNT_EN 2
`define TQS_CTRL_CNT_TIME 3
`define TQS_CTRL_PER_LEVEL 4
`define TQS_CTRL_LAST_LSB 5

// ======================================================================
// Interrupt bit positions
`define TQS_INT_TRIG 0
`define TQS_INT_RESTART 1

// ======================================================================
// Reset values and tag constants
`define TQS_CTRL_RESET 32'h0000_0000
`define TQS_QSEL_RESET 20'h0_0010
`define TQS_LEVEL_RESET 12'h010
`define TQS_PRE_MARK 16'hFFFF
`define TQS_CNT_MAX 16'hFFFE

`endif

// ===== tqs_pkg.sv
// ======================================================================
// Shared types
package tqs_pkg;
   localparam int TQS_SW = 32;
   localparam int TQS_TW = 16;

   // Sequencer run state
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_SEARCH, SEQ_DONE} tqsSeq_t;

   // Qualifier select: bit 4 is any state, bits 3:0 pick pattern terms
   typedef struct packed {
      logic [4:0] restartQ;
      logic [4:0] countQ;
      logic [4:0] preQ;
      logic [4:0] storeQ;
   } tqsQsel_t;

   // One sequence level
   typedef struct packed {
      logic [1:0] dest;
      logic [4:0] branchQ;
      logic [4:0] searchQ;
   } tqsLevel_t;

   // One trace entry: state and its tag (count or prestore marker)
   typedef struct packed {
      logic [TQS_SW-1:0] state;
      logic [TQS_TW-1:0] tag;
   } tqsEntry_t;

   // Record: slot 0 older prestore, slot 1 newer prestore, slot 2 normal
   typedef struct packed {
      logic [2:0] valid;
      tqsEntry_t [2:0] slot;
   } tqsTrace_t;
endpackage : tqs_pkg

// ===== tqs_term_match.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Masked pattern compare of one bus state
module tqs_term_match #(
   parameter int W = 32
) (
   // Compare inputs
   input wire logic [W-1:0] state,
   input wire logic [W-1:0] value,
   input wire logic [W-1:0] mask,
   // Result
   output logic hit
);
   // Only bits with mask set take part
   assign hit = (((state ^ value) & mask) == '0);
endmodule : tqs_term_match
`default_nettype wire

// ===== tqs_trace_qualifier.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tqs_params.svh"
module tqs_trace_qualifier #(
   parameter int NTERM = 4,
   parameter int NLEV = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Monitored bus states
   input wire logic busValid,
   input wire logic [tqs_pkg::TQS_SW-1:0] busState,
   // Trace memory side
   output tqs_pkg::tqsTrace_t traceOut,
   output logic trigger,
   output logic irq
);
   import tqs_pkg::*;

   // ===================================================================
   // Register state
   logic cntEn;
   logic cntTime;
   logic perLevel;
   logic [1:0] lastLevel;
   tqsQsel_t qsel;
   tqsLevel_t lvl [NLEV];
   logic [TQS_SW-1:0] termVal [NTERM];
   logic [TQS_SW-1:0] termMask [NTERM];
   logic [1:0] intStat;
   logic [1:0] intMask;

   // Sequencer and capture state
   tqsSeq_t seq;
   logic [1:0] cur;
   logic [TQS_TW-1:0] cnt;
   logic [1:0] preVal;
   logic [TQS_SW-1:0] preState [2];

   // ===================================================================
   // Helper functions
   function automatic logic qualHit(input logic [4:0] sel,
                                    input logic [3:0] h);
      qualHit = sel[4] | (|(sel[3:0] & h));
   endfunction : qualHit

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a[1:0] == 2'h0) &&
         ((a <= `TQS_QSEL) ||
          (a >= `TQS_LEVEL_BASE && a < `TQS_LEVEL_BASE + 8'h10) ||
          (a >= `TQS_TERM_BASE && a <= `TQS_TERM_END));
   endfunction : isMapped

   // ===================================================================
   // Pattern terms
   logic [NTERM-1:0] termHit;
   logic [3:0] hits;
   genvar gi;
   generate
      for (gi = 0; gi < NTERM; gi++) begin : g_term
         tqs_term_match #(.W(TQS_SW)) u_match (
            .state(busState),
            .value(termVal[gi]),
            .mask(termMask[gi]),
            .hit(termHit[gi])
         );
      end
   endgenerate
   assign hits = 4'(termHit);

   // ===================================================================
   // APB access decode
   logic apbSetup;
   logic apbWrite;
   logic beginPulse;
   logic haltPulse;
   assign apbSetup = psel & ~penable;
   assign apbWrite = psel & penable & pwrite & ~pslverr;
   assign beginPulse = apbWrite && paddr == `TQS_CTRL &&
      pwdata[`TQS_CTRL_BEGIN];
   assign haltPulse = apbWrite && paddr == `TQS_CTRL &&
      pwdata[`TQS_CTRL_HALT];
   // Fixed one access cycle, data prepared in setup
   assign pready = 1'b1;

   // ===================================================================
   // Qualification of the current state
   logic act;
   logic searching;
   logic searchMet;
   logic restartMet;
   logic branchMet;
   logic trigNow;
   logic normalHit;
   logic preHit;
   logic countHit;
   tqsLevel_t curLvl;
   assign act = busValid & (seq != SEQ_IDLE);
   assign searching = busValid & (seq == SEQ_SEARCH);
   assign curLvl = lvl[cur];
   assign searchMet = searching & qualHit(curLvl.searchQ, hits);
   assign restartMet = searching & ~perLevel &
      qualHit(qsel.restartQ, hits);
   assign branchMet = searching & perLevel & qualHit(curLvl.branchQ, hits);
   assign trigNow = searchMet & (cur == lastLevel);
   // Store wins over prestore; trigger state always stored
   assign normalHit = act &
      (qualHit(qsel.storeQ, hits) | trigNow);
   assign preHit = act & ~normalHit & qualHit(qsel.preQ, hits);
   assign countHit = act & qualHit(qsel.countQ, hits);

   // ===================================================================
   // Control registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cntEn <= 1'b0;
         cntTime <= 1'b0;
         perLevel <= 1'b0;
         lastLevel <= 2'h0;
         qsel <= `TQS_QSEL_RESET;
      end else if (apbWrite) begin
         if (paddr == `TQS_CTRL) begin
            cntEn <= pwdata[`TQS_CTRL_CNT_EN];
            cntTime <= pwdata[`TQS_CTRL_CNT_TIME];
            perLevel <= pwdata[`TQS_CTRL_PER_LEVEL];
            lastLevel <= pwdata[`TQS_CTRL_LAST_LSB +: 2];
         end
         if (paddr == `TQS_QSEL) begin
            qsel <= pwdata[19:0];
         end
      end
   end

   // Level and term tables
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < NLEV; i++) begin
            lvl[i] <= `TQS_LEVEL_RESET;
         end
         for (int i = 0; i < NTERM; i++) begin
            termVal[i] <= '0;
            termMask[i] <= '0;
         end
      end else if (apbWrite) begin
         if (paddr[7:4] == `TQS_LEVEL_BASE >> 4) begin
            lvl[paddr[3:2]] <= pwdata[11:0];
         end
         if (paddr[7:5] == `TQS_TERM_BASE >> 5) begin
            if (paddr[2]) begin
               termMask[paddr[4:3]] <= pwdata;
            end else begin
               termVal[paddr[4:3]] <= pwdata;
            end
         end
      end
   end

   // ===================================================================
   // Sequencer: begin restarts, halt stops, trigger holds
   always_ff @(posedge clk) begin
      if (!rstn) begin
         seq <= SEQ_IDLE;
         cur <= 2'h0;
      end else if (beginPulse) begin
         seq <= SEQ_SEARCH;
         cur <= 2'h0;
      end else if (haltPulse) begin
         seq <= SEQ_IDLE;
      end else begin
         case (seq)
            SEQ_SEARCH: begin
               // Search has priority over restart and branch in one cycle
               if (trigNow) begin
                  seq <= SEQ_DONE;
               end else if (searchMet) begin
                  cur <= cur + 2'h1;
               end else if (restartMet) begin
                  cur <= 2'h0;
               end else if (branchMet) begin
                  cur <= curLvl.dest;
               end
            end
            SEQ_IDLE: begin
               cur <= cur;
            end
            SEQ_DONE: begin
               cur <= cur;
            end
            default: begin
               seq <= SEQ_IDLE;
            end
         endcase
      end
   end
   assign trigger = (seq == SEQ_DONE);

   // ===================================================================
   // Count accumulator, saturating below the prestore marker
   always_ff @(posedge clk) begin
      if (!rstn || beginPulse) begin
         cnt <= '0;
      end else if (normalHit) begin
         cnt <= '0;
      end else if (seq != SEQ_IDLE && cnt != `TQS_CNT_MAX &&
                   (cntTime || countHit)) begin
         cnt <= cnt + 16'h0001;
      end
   end

   // ===================================================================
   // Prestore holding pair; keeps only the two newest
   always_ff @(posedge clk) begin
      if (!rstn || beginPulse || normalHit) begin
         preVal <= 2'b00;
      end else if (preHit) begin
         preVal <= {1'b1, preVal[1]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         preState[0] <= '0;
         preState[1] <= '0;
      end else if (preHit) begin
         preState[0] <= preState[1];
         preState[1] <= busState;
      end
   end

   // ===================================================================
   // Trace record: prestores ahead of the normal state
   logic [TQS_TW-1:0] preTag;
   assign preTag = cntEn ? `TQS_PRE_MARK : '0;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         traceOut <= '0;
      end else begin
         traceOut.valid <= normalHit ? {1'b1, preVal} : 3'b000;
         traceOut.slot[0] <= '{state: preState[0], tag: preTag};
         traceOut.slot[1] <= '{state: preState[1], tag: preTag};
         traceOut.slot[2] <= '{state: busState,
                               tag: cntEn ? cnt : '0};
      end
   end

   // ===================================================================
   // Interrupts: sticky, write one to clear, set beats clear
   logic [1:0] intSet;
   logic [1:0] intClr;
   assign intSet = {restartMet & (cur != 2'h0) & ~searchMet, trigNow};
   assign intClr = (apbWrite && paddr == `TQS_INT_STAT) ?
      pwdata[1:0] : 2'b00;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         intStat <= 2'b00;
         intMask <= 2'b00;
      end else begin
         intStat <= (intStat & ~intClr) | intSet;
         if (apbWrite && paddr == `TQS_INT_MASK) begin
            intMask <= pwdata[1:0];
         end
      end
   end
   assign irq = |(intStat & intMask);

   // ===================================================================
   // Read data prepared in the setup cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (apbSetup) begin
         pslverr <= ~isMapped(paddr);
         prdata <= '0;
         if (!pwrite) begin
            case (paddr)
               `TQS_CTRL: prdata <= {25'h0, lastLevel, perLevel, cntTime,
                                     cntEn, 2'b00};
               `TQS_STATUS: prdata <= {26'h0, preVal, seq, cur};
               `TQS_INT_STAT: prdata <= {30'h0, intStat};
               `TQS_INT_MASK: prdata <= {30'h0, intMask};
               `TQS_QSEL: prdata <= {12'h0, qsel};
               default: begin
                  if (paddr[7:4] == `TQS_LEVEL_BASE >> 4) begin
                     prdata <= {20'h0, lvl[paddr[3:2]]};
                  end else if (paddr[7:5] == `TQS_TERM_BASE >> 5) begin
                     prdata <= paddr[2] ? termMask[paddr[4:3]] :
                        termVal[paddr[4:3]];
                  end
               end
            endcase
         end
      end
   end
endmodule : tqs_trace_qualifier
`default_nettype wire

// ===== tqs_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module tqs_checker
   import tqs_pkg::*;
(
   // Clock, reset and bus
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   // Monitored states and results
   input wire logic busValid,
   input wire tqs_pkg::tqsTrace_t traceOut,
   input wire logic trigger
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Begin or halt written in this access
   wire logic clr = psel && penable && pwrite && paddr == 8'h00
                    && |pwdata[1:0];
   a_trig_holds: assert property (trigger && !clr |=> trigger)
      else $error("trigger dropped");
   a_trig_stored: assert property ($rose(trigger) |->
      traceOut.valid[2])
      else $error("trigger state not stored");
   a_pre_marker: assert property (traceOut.valid[1] |->
      traceOut.slot[1].tag inside {16'hFFFF, 16'h0000})
      else $error("prestore tag wrong");
   a_pre_with_norm: assert property (|traceOut.valid[1:0] |->
      traceOut.valid[2])
      else $error("prestore without normal state");
   a_pre_order: assert property (traceOut.valid[0] |->
      traceOut.valid[1])
      else $error("older prestore without newer");
   a_norm_tag: assert property (traceOut.valid[2] |->
      traceOut.slot[2].tag != 16'hFFFF)
      else $error("normal state carries marker");
   a_store_cause: assert property (|traceOut.valid |-> $past(busValid))
      else $error("record without bus state");
   a_begin_clears: assert property (clr |=> !trigger)
      else $error("trigger kept over begin");
endmodule : tqs_checker
`default_nettype wire

// ===== tqs_bus_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Target bus: one state per clock during a burst
module tqs_bus_source (
   // Clock
   input wire logic clk,
   // Bus states
   output logic busValid,
   output logic [31:0] busState
);
   initial begin
      busValid = 1'b0;
      busState = 32'h0000_0000;
   end
   // Idle bus shows the inverse word, so a stale state never matches
   task automatic play(input logic [31:0] q [$]);
      foreach (q[i]) begin
         busValid <= 1'b1;
         busState <= q[i];
         @(posedge clk);
      end
      busValid <= 1'b0;
      busState <= ~busState;
   endtask : play
endmodule : tqs_bus_source
`default_nettype wire

// ===== test_trace_qualifier_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tqs_params.svh"
// ==========
// Bench with a reference model of qualifier and sequencer
module test_trace_qualifier_sequencer;
   import tqs_pkg::*;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, errv;
   logic busValid, trigger, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, busState, rdv, ctrl, qsel, lv [4];
   tqsTrace_t traceOut;
   int miscompares = 0, tests_run = 0, lvl, cnt;
   bit done;
   tqsEntry_t pend [$];
   tqsTrace_t expq [$];
   tqs_trace_qualifier dut_u (.clk(clk), .rstn(rstn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .busValid(busValid), .busState(busState), .traceOut(traceOut),
      .trigger(trigger), .irq(irq));
   tqs_bus_source partner_u (.clk(clk), .busValid(busValid),
      .busState(busState));
   // ==========
   // Clock and shared tasks
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chkRec(tqsTrace_t e, tqsTrace_t g);
      chk("valid", {29'h0, e.valid}, {29'h0, g.valid});
      for (int i = 0; i < 3; i++) begin
         if (e.valid[i]) begin
            chk("state", e.slot[i].state, g.slot[i].state);
            chk("tag", {16'h0, e.slot[i].tag}, {16'h0, g.slot[i].tag});
         end
      end
   endtask : chkRec
   // One transfer then one idle cycle, so no signal is set twice at once
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) miscompares++;
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d);
      if (a == `TQS_QSEL) qsel = d;
      if (a[7:4] == 4'h2) lv[a[3:2]] = d;
   endtask : wr
   task automatic setCtrl(logic [31:0] v);
      wr(`TQS_CTRL, v);
      ctrl = v;
      if (v[0]) begin
         lvl = 0;
         // Time mode: one running clock passes before the first state
         cnt = v[3] ? 1 : 0;
         done = 0;
         pend.delete();
      end
   endtask : setCtrl
   // ==========
   // Reference model
   function automatic bit hit(logic [4:0] q, logic [31:0] s);
      logic [3:0] t;
      for (int i = 0; i < 4; i++)
         t[i] = ((s ^ ((i + 1) << 12)) & 32'hFFFF_FF00) == 32'h0;
      return q[4] | |(q[3:0] & t);
   endfunction : hit
   // Term t word with random low byte; t of 4 matches no term
   function automatic logic [31:0] w(int t);
      return (t < 4) ? (((t + 1) << 12) | ($urandom & 32'hFF))
                     : (32'h8000_0000 | $urandom);
   endfunction : w
   task automatic step(logic [31:0] s);
      tqsTrace_t r;
      bit st, tr;
      tr = 0;
      if (!done) begin
         if (hit(lv[lvl][4:0], s)) begin
            done = (lvl == ctrl[6:5]);
            tr = done;
            if (!done) lvl++;
         end else if (!ctrl[4] && hit(qsel[19:15], s)) begin
            lvl = 0;
         end else if (ctrl[4] && hit(lv[lvl][9:5], s)) begin
            lvl = lv[lvl][11:10];
         end
      end
      st = hit(qsel[4:0], s) || tr;
      if (st) begin
         r = '0;
         r.valid = 3'b100;
         foreach (pend[i]) begin
            r.slot[i + 2 - pend.size()] = pend[i];
            r.valid[i + 2 - pend.size()] = 1'b1;
         end
         r.slot[2] = {s, ctrl[2] ? 16'(cnt) : 16'h0000};
         expq.push_back(r);
         cnt = 0;
         pend.delete();
      end else if (hit(qsel[9:5], s)) begin
         pend.push_back({s, ctrl[2] ? 16'hFFFF : 16'h0000});
         if (pend.size() > 2) void'(pend.pop_front());
      end
      // Time mode counts every clock, state mode only qualifying states
      if (!st && (ctrl[3] || hit(qsel[14:10], s))) cnt++;
   endtask : step
   task automatic send(logic [31:0] q [$]);
      foreach (q[i]) step(q[i]);
      partner_u.play(q);
   endtask : send
   // Every record is checked against the model while valid stands
   always @(negedge clk) begin
      if (rstn && traceOut.valid !== 3'b000) begin
         if (expq.size() == 0) chk("record", 32'h0, 32'h1);
         else chkRec(expq.pop_front(), traceOut);
      end
   end
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
   // ==========
   // Scenarios
   initial begin
      logic [31:0] q [$];
      rstn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {ctrl, lvl, cnt, done} = '0;
      done = 1;
      qsel = `TQS_QSEL_RESET;
      foreach (lv[i]) lv[i] = `TQS_LEVEL_RESET;
      void'($urandom(32'h2b669327));
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      apb(1'b0, `TQS_QSEL, 32'h0);
      chk("qselReset", `TQS_QSEL_RESET, rdv);
      apb(1'b0, `TQS_LEVEL_BASE, 32'h0);
      chk("levelReset", `TQS_LEVEL_RESET, rdv);
      apb(1'b0, 8'h80, 32'h0);
      chk("unmapped", 32'h1, {31'h0, errv});
      for (int t = 0; t < 4; t++) begin
         wr(`TQS_TERM_BASE + 8'(8 * t), (t + 1) << 12);
         wr(`TQS_TERM_BASE + 8'(8 * t + 4), 32'hFFFF_FF00);
      end
      // Prestores with counting off, then on
      wr(`TQS_QSEL, {12'h0, 5'h0, 5'h0, 5'b00011, 5'b00001});
      for (int m = 0; m < 2; m++) begin
         setCtrl(32'h1 | (m << 2));
         q = {w(4), w(1), w(1), w(1), w(0), w(1), w(0), w(0)};
         send(q);
      end
      q = {w(1)};
      send(q);
      setCtrl(32'h1);
      q = {w(4), w(0)};
      send(q);
      // Counting a qualifying state, zero included
      wr(`TQS_QSEL, {12'h0, 5'h0, 5'b00100, 5'h0, 5'b00001});
      setCtrl(32'h5);
      q = {w(4)};
      repeat ($urandom_range(20, 1)) q = {q, w(2), w(4)};
      q = {q, w(0), w(0)};
      send(q);
      // Time tags: clocks since the last normal store
      setCtrl(32'hD);
      q = {w(4)};
      repeat ($urandom_range(8, 1)) q = {q, w(2)};
      q = {q, w(0), w(1), w(0)};
      send(q);
      // Restart mode over two levels
      wr(`TQS_QSEL, {12'h0, 5'b00100, 15'h0});
      wr(`TQS_LEVEL_BASE, 32'h1);
      wr(`TQS_LEVEL_BASE + 8'h04, 32'h2);
      setCtrl(32'h21);
      q = {w(0), w(2), w(1), w(0), w(4), w(1), w(1)};
      send(q);
      chk("trigger", 32'h1, {31'h0, trigger});
      apb(1'b0, `TQS_STATUS, 32'h0);
      chk("seqState", 32'h2, {30'h0, rdv[3:2]});
      apb(1'b0, `TQS_INT_STAT, 32'h0);
      chk("intStat", 32'h3, rdv);
      chk("irqMasked", 32'h0, {31'h0, irq});
      wr(`TQS_INT_MASK, 32'h1);
      chk("irqOn", 32'h1, {31'h0, irq});
      wr(`TQS_INT_STAT, 32'h1);
      chk("irqOff", 32'h0, {31'h0, irq});
      // Per-level branch to a chosen destination, restart ignored
      wr(`TQS_LEVEL_BASE + 8'h04, 32'h902);
      wr(`TQS_LEVEL_BASE + 8'h08, 32'h4);
      setCtrl(32'h51);
      q = {w(0), w(2), w(3), w(2)};
      send(q);
      // Trigger state is the last one, so let its edge pass first
      @(posedge clk);
      chk("branchTrig", 32'h1, {31'h0, trigger});
      // Halt stops the sequencer and drops the trigger
      wr(`TQS_CTRL, 32'h2);
      chk("haltTrig", 32'h0, {31'h0, trigger});
      apb(1'b0, `TQS_STATUS, 32'h0);
      chk("haltState", 32'h0, {30'h0, rdv[3:2]});
      repeat (3) @(posedge clk);
      chk("leftOver", 32'h0, expq.size());
      conclude();
   end
endmodule : test_trace_qualifier_sequencer
bind tqs_trace_qualifier tqs_checker chk_u (.clk(clk), .rstn(rstn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .busValid(busValid), .traceOut(traceOut),
   .trigger(trigger));
`default_nettype wire
